// ---- design/ppc_capture.sv ----
`timescale 1ns/1ns
`default_nettype none
module ppc_capture (
	// dot clock drives everything here
	input wire logic clk_i,
	input wire logic rst_i,
	// sequencing select: 1 external, 0 internal
	input wire logic ext_seq_i,
	// internal sequencer levels, used when ext_seq_i is low
	input wire logic int_supply_i,
	input wire logic int_contrast_i,
	// port
	ppc_if.dev port,
	// captured stream
	output logic [17:0] pixel_word_o,
	output logic pixel_valid_o,
	output logic line_blank_o,
	output logic frame_blank_o,
	// panel power
	output logic panel_supply_en_o,
	output logic panel_contrast_en_o
);
	// capture stage: every port signal is registered once on the dot clock
	// no buffering; each captured word stands for exactly one cycle
	// limitation: sync pulse widths are not checked, the source owns timing
	localparam int NUM_CHAN = 3;
	// field position of each channel, index 0 is the top channel
	localparam int CHAN_LSB [NUM_CHAN] = '{ppc_pkg::CH0_LSB, ppc_pkg::CH1_LSB, ppc_pkg::CH2_LSB};

	// channel views of the port
	ppc_pkg::ppc_chan_t chan_in [NUM_CHAN];
	// captured channels, one register each
	ppc_pkg::ppc_chan_t chan_q [NUM_CHAN];
	ppc_pkg::ppc_chan_t chan_d [NUM_CHAN];

	always_comb begin
		chan_in[0] = port.chan0;
		chan_in[1] = port.chan1;
		chan_in[2] = port.chan2;
	end

	// one capture register per colour channel
	for (genvar c = 0; c < NUM_CHAN; c++) begin : g_chan
		// straight copy; the register is the only stage
		always_comb begin
			chan_d[c] = chan_in[c];
		end

		// all channels share one edge, so a word never tears
		// reset value comes from the package, all channels alike
		always_ff @(posedge clk_i or posedge rst_i) begin
			if (rst_i) begin
				chan_q[c] <= ppc_pkg::CHAN_RST;
			end else begin
				chan_q[c] <= chan_d[c];
			end
		end
	end

	// word view of the captured channels, wiring only
	// positions from the package so the mapping lives in one place
	ppc_pkg::ppc_word_t word_cap;

	always_comb begin
		word_cap = ppc_pkg::WORD_RST;
		for (int k = 0; k < NUM_CHAN; k++) begin
			word_cap[CHAN_LSB[k] +: ppc_pkg::CHAN_W] = chan_q[k];
		end
	end

	// line blanking
	// carried through unmasked; downstream timing needs the raw level
	logic lb_q;
	logic lb_d;

	always_comb begin
		lb_d = port.line_blank_in;
	end

	// async reset to the idle level
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			lb_q <= 1'b0;
		end else begin
			lb_q <= lb_d;
		end
	end

	// frame blanking
	// carried through unmasked, same latency as the word
	logic fb_q;
	logic fb_d;

	always_comb begin
		fb_d = port.frame_blank_in;
	end

	// async reset to the idle level
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			fb_q <= 1'b0;
		end else begin
			fb_q <= fb_d;
		end
	end

	// display qualifier
	// blanking overrides the qualifier so a glitchy source cannot leak data
	// costs nothing in latency, the mask sits before the register
	logic val_q;
	logic val_d;
	logic blank_any;

	always_comb begin
		blank_any = port.line_blank_in | port.frame_blank_in;
		val_d = 1'b0;
		if (port.active_video_in && !blank_any) begin
			val_d = 1'b1;
		end
	end

	// async reset: no word counts as valid until the source has run
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			val_q <= 1'b0;
		end else begin
			val_q <= val_d;
		end
	end

	// sequencing select
	// a plain pin, so it may change at any edge; both enables switch together
	// compared against the package constant so the polarity lives in one place
	logic ext_sel;

	always_comb begin
		ext_sel = (ext_seq_i == ppc_pkg::SEQ_EXTERNAL);
	end

	// panel supply enable
	// request ignored under internal sequencing
	// the internal sequencer itself lives outside this block
	logic sup_q;
	logic sup_d;

	always_comb begin
		if (ext_sel) begin
			sup_d = port.panel_supply_req;
		end else begin
			sup_d = int_supply_i;
		end
	end

	// async reset: panel unpowered until asked
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			sup_q <= 1'b0;
		end else begin
			sup_q <= sup_d;
		end
	end

	// panel contrast enable
	// no ordering against supply here; whoever requests sequences them
	logic con_q;
	logic con_d;

	always_comb begin
		if (ext_sel) begin
			con_d = port.panel_contrast_req;
		end else begin
			con_d = int_contrast_i;
		end
	end

	// async reset: contrast off until asked
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			con_q <= 1'b0;
		end else begin
			con_q <= con_d;
		end
	end

	// captured stream, one edge after the port inputs
	assign pixel_word_o = word_cap;
	assign pixel_valid_o = val_q;
	assign line_blank_o = lb_q;
	assign frame_blank_o = fb_q;

	// panel power
	assign panel_supply_en_o = sup_q;
	assign panel_contrast_en_o = con_q;
endmodule
`default_nettype wire

// ---- design/ppc_pkg.sv ----
package ppc_pkg;
	localparam int CHAN_W = 6;
	localparam int WORD_W = 18;
	// channel field positions inside the 18-bit word
	localparam int CH0_LSB = 12;
	localparam int CH1_LSB = 6;
	localparam int CH2_LSB = 0;
	localparam logic [WORD_W-1:0] WORD_RST = 18'h00000;
	localparam logic [CHAN_W-1:0] CHAN_RST = 6'h00;
	localparam logic SEQ_EXTERNAL = 1'b1;
	typedef logic [CHAN_W-1:0] ppc_chan_t;
	typedef logic [WORD_W-1:0] ppc_word_t;
endpackage

// ---- design/ppc_if.sv ----
`timescale 1ns/1ns
`default_nettype none
interface ppc_if;
	ppc_pkg::ppc_chan_t chan0;
	ppc_pkg::ppc_chan_t chan1;
	ppc_pkg::ppc_chan_t chan2;
	logic active_video_in;
	logic line_blank_in;
	logic frame_blank_in;
	logic panel_supply_req;
	logic panel_contrast_req;
	modport src (
		output chan0, chan1, chan2, active_video_in, line_blank_in, frame_blank_in,
		output panel_supply_req, panel_contrast_req
	);
	modport dev (
		input chan0, chan1, chan2, active_video_in, line_blank_in, frame_blank_in,
		input panel_supply_req, panel_contrast_req
	);
endinterface
`default_nettype wire

// ---- design/ppc_source.sv ----
`timescale 1ns/1ns
`default_nettype none
module ppc_source (
	// clock and reset; clk_i is the dot clock, kept running after reset
	input wire logic clk_i,
	input wire logic rst_i,
	// user side
	input wire ppc_pkg::ppc_word_t upstream_pixel_word_i,
	input wire logic active_video_i,
	input wire logic line_blank_i,
	input wire logic frame_blank_i,
	input wire logic supply_req_i,
	input wire logic contrast_req_i,
	// port
	ppc_if.src port
);
	ppc_pkg::ppc_word_t word_q, word_d;
	logic act_q, act_d, lb_q, lb_d, fb_q, fb_d, sup_q, sup_d, con_q, con_d;

	always_comb begin
		word_d = upstream_pixel_word_i;
		// qualifier only while not blanking
		act_d = active_video_i & ~line_blank_i & ~frame_blank_i;
		lb_d = line_blank_i;
		fb_d = frame_blank_i;
		sup_d = supply_req_i;
		con_d = contrast_req_i;
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			word_q <= ppc_pkg::WORD_RST;
			act_q <= 1'b0;
			lb_q <= 1'b0;
			fb_q <= 1'b0;
			sup_q <= 1'b0;
			con_q <= 1'b0;
		end else begin
			word_q <= word_d;
			act_q <= act_d;
			lb_q <= lb_d;
			fb_q <= fb_d;
			sup_q <= sup_d;
			con_q <= con_d;
		end
	end

	assign port.chan0 = word_q[ppc_pkg::CH0_LSB +: ppc_pkg::CHAN_W];
	assign port.chan1 = word_q[ppc_pkg::CH1_LSB +: ppc_pkg::CHAN_W];
	assign port.chan2 = word_q[ppc_pkg::CH2_LSB +: ppc_pkg::CHAN_W];
	assign port.active_video_in = act_q;
	assign port.line_blank_in = lb_q;
	assign port.frame_blank_in = fb_q;
	assign port.panel_supply_req = sup_q;
	assign port.panel_contrast_req = con_q;
endmodule
`default_nettype wire

// ---- dv/ppc_capture_asserts.sv ----
`timescale 1ns/1ns
`default_nettype none
module ppc_capture_asserts (
	input wire logic clk_i, rst_i, ext_seq_i, pixel_valid_o, panel_supply_en_o, panel_contrast_en_o,
	input wire logic [5:0] chan0, chan1, chan2,
	input wire logic [17:0] pixel_word_o,
	input wire logic active_video_in, line_blank_in, frame_blank_in, panel_supply_req, panel_contrast_req
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	property p_hi; pixel_word_o[17:12]==$past(chan0); endproperty
	a_hi: assert property (p_hi) else $error("hi");
	property p_md; pixel_word_o[11:6]==$past(chan1); endproperty
	a_md: assert property (p_md) else $error("mid");
	property p_lo; pixel_word_o[5:0]==$past(chan2); endproperty
	a_lo: assert property (p_lo) else $error("lo");
	property p_va; pixel_valid_o==$past(active_video_in&!line_blank_in&!frame_blank_in); endproperty
	a_va: assert property (p_va) else $error("valid");
	property p_su; $past(ext_seq_i) |-> panel_supply_en_o==$past(panel_supply_req); endproperty
	a_su: assert property (p_su) else $error("supply");
	property p_co; $past(ext_seq_i) |-> panel_contrast_en_o==$past(panel_contrast_req); endproperty
	a_co: assert property (p_co) else $error("contrast");
	property p_lb; line_blank_in[*2] |=> !pixel_valid_o; endproperty
	a_lb: assert property (p_lb) else $error("line");
	property p_fb; frame_blank_in[*2] |=> !pixel_valid_o; endproperty
	a_fb: assert property (p_fb) else $error("frame");
	cover property (pixel_valid_o);
	cover property (!ext_seq_i ##1 ext_seq_i);
	cover property (panel_supply_en_o&panel_contrast_en_o);
endmodule
`default_nettype wire

// ---- dv/tb.sv ----
`timescale 1ns/1ns
`default_nettype none
module tb;
	logic clk_i=0, rst_i=1, ext_seq_i=0, int_supply_i=0, int_contrast_i=0, supply_req_i=0, contrast_req_i=0;
	logic active_video_i=0, line_blank_i=0, frame_blank_i=0, pixel_valid_o, line_blank_o, frame_blank_o;
	logic panel_supply_en_o, panel_contrast_en_o;
	logic [17:0] upstream_pixel_word_i=0, pixel_word_o;
	int err_count=0, check_count=0;
	ppc_if u();
	ppc_source i_ppc_source (.clk_i(clk_i), .rst_i(rst_i), .upstream_pixel_word_i(upstream_pixel_word_i),
		.active_video_i(active_video_i), .line_blank_i(line_blank_i), .frame_blank_i(frame_blank_i),
		.supply_req_i(supply_req_i), .contrast_req_i(contrast_req_i), .port(u.src));
	ppc_capture i_ppc_capture (.clk_i(clk_i), .rst_i(rst_i), .ext_seq_i(ext_seq_i), .int_supply_i(int_supply_i),
		.int_contrast_i(int_contrast_i), .port(u.dev), .pixel_word_o(pixel_word_o), .pixel_valid_o(pixel_valid_o),
		.line_blank_o(line_blank_o), .frame_blank_o(frame_blank_o), .panel_supply_en_o(panel_supply_en_o),
		.panel_contrast_en_o(panel_contrast_en_o));
	ppc_capture_asserts ca (.clk_i(clk_i), .rst_i(rst_i), .ext_seq_i(ext_seq_i), .pixel_valid_o(pixel_valid_o),
		.panel_supply_en_o(panel_supply_en_o), .panel_contrast_en_o(panel_contrast_en_o),
		.pixel_word_o(pixel_word_o), .chan0(u.chan0), .chan1(u.chan1), .chan2(u.chan2),
		.active_video_in(u.active_video_in), .line_blank_in(u.line_blank_in), .frame_blank_in(u.frame_blank_in),
		.panel_supply_req(u.panel_supply_req), .panel_contrast_req(u.panel_contrast_req));
	initial forever #5 clk_i = ~clk_i;
	task chk(input logic [17:0] g, e);
		check_count++;
		if (g !== e) begin
			err_count++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task t_chan();
		logic [17:0] p[4] = '{18'h3f000, 18'h00fc0, 18'h0003f, 18'h2a815};
		foreach (p[i]) begin
			@(posedge clk_i);
			upstream_pixel_word_i <= p[i];
			@(posedge clk_i);
			#1 chk({u.chan0, u.chan1, u.chan2}, p[i]);
			@(posedge clk_i);
			#1 chk(pixel_word_o, p[i]);
		end
	endtask
	task t_valid();
		for (int i = 0; i < 8; i++) begin
			@(posedge clk_i);
			{active_video_i, line_blank_i, frame_blank_i} <= i[2:0];
			repeat (2) @(posedge clk_i);
			#1 chk({pixel_valid_o, line_blank_o, frame_blank_o}, {i==4, i[1:0]});
		end
	endtask
	task t_power();
		for (int i = 0; i < 32; i++) begin
			@(posedge clk_i);
			{ext_seq_i, supply_req_i, contrast_req_i, int_supply_i, int_contrast_i} <= i[4:0];
			repeat (2) @(posedge clk_i);
			#1 chk({panel_supply_en_o, panel_contrast_en_o}, i[4] ? i[3:2] : i[1:0]);
		end
	endtask
	task complete_run();
		$display("errors %0d checks %0d", err_count, check_count);
		if (err_count == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge clk_i);
		rst_i <= 0;
		t_chan();
		t_valid();
		t_power();
		complete_run();
	end
	// about 140 cycles of tests, so this only trips on a hang
	initial begin
		#5000;
		err_count++;
		complete_run();
	end
endmodule
`default_nettype wire
